// ### inc/urxsf_map.svh
// Purpose: Register offsets, field positions and reset values of the receive status block.
// Assumes: AXI4-Lite slave with 32-bit data, one register per aligned word.
// Notes: Definitions only.
`ifndef URXSF_MAP_SVH
`define URXSF_MAP_SVH
`define URXSF_OFF_CTRL 4'h0
`define URXSF_OFF_STAT 4'h4
`define URXSF_OFF_DATA 4'h8
`define URXSF_OFF_IRQ 4'hC
`define URXSF_CTRL_PORT_EN 0
`define URXSF_CTRL_RX_ON 1
`define URXSF_CTRL_NINE_BIT 2
`define URXSF_CTRL_ADDR_DET 3
`define URXSF_STAT_RDY 0
`define URXSF_STAT_FRAME 1
`define URXSF_STAT_OVERRUN 2
`define URXSF_STAT_NINTH 3
`define URXSF_IRQ_RX_EN 0
`define URXSF_IRQ_PERIPH_EN 1
`define URXSF_IRQ_GLOBAL_EN 2
`define URXSF_CTRL_RST 4'h0
`define URXSF_IRQ_RST 3'h0
`define URXSF_FIFO_DEPTH 2
`endif

// ### inc/urxsf_pkg.sv
// Purpose: Types shared by the receive status block.
// Assumes: Nothing beyond the map header.
// Notes: One FIFO entry carries data, ninth bit and framing error.
package urxsf_pkg;
	typedef struct packed {
		logic frame_err;
		logic ninth;
		logic [7:0] data;
	} urxsf_char_s;
	typedef enum logic [2:0] {
		URXSF_WIDLE = 3'h1,
		URXSF_WRESP = 3'h2,
		URXSF_WHOLD = 3'h4
	} urxsf_wst_e;
	typedef logic [1:0] urxsf_resp_t;
endpackage

// ### src/urxsf_top.sv
// Purpose: Receive FIFO, status flags, address filter and register file of a serial receiver.
// Assumes: Characters arrive from the shifter as a one-cycle strobe with data, ninth bit and stop-bit status.
// Notes: Registers at 0x0 control, 0x4 status, 0x8 data (read pops), 0xC interrupt enables.
// Behaviour
// R1: Ready flag set when enabled and FIFO non-empty.
// R2: Ready flag is read-only, occupancy only.
// R3: Interrupt needs all three enables set.
// R4: Ready flag ignores interrupt enables.
// R5: Each entry stores its framing error bit.
// R6: Presented framing error is oldest entry's.
// R7: Data register read pops FIFO.
// R8: Software reads framing error before data.
// R9: Framing error never stops reception.
// R10: Port disable resets block, clears framing error.
// R11: Receive disable keeps framing error unchanged.
// R12: Framing error alone raises no interrupt.
// R13: Third character into full FIFO sets overrun.
// R14: Overrun blocks new characters, old stay readable.
// R15: Overrun clears only via receive or port disable.
// R16: Nine-bit mode shifts nine data bits.
// R17: Ninth bit stored per entry, oldest presented.
// R18: Software reads ninth bit before low byte.
// R19: Address detect valid only in nine-bit mode.
// R20: Address detect keeps only ninth-bit-set characters.
// R21: Software clears address detect before next stop.
// R22: Software sets address detect at message end.
// R23: Characters delivered in received order.
`timescale 1ns/10ps
`include "urxsf_map.svh"
module urxsf_top
	import urxsf_pkg::*;
#(
	parameter int DEPTH = `URXSF_FIFO_DEPTH
) (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic rx_done_i,
	input wire logic [8:0] rx_shift_reg_i,
	input wire logic rx_stop_ok_i,
	output logic nine_bit_rx_enable_o,
	output logic rx_enable_o,
	output logic rx_irq_o,
	input wire logic [3:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [3:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i
);
	localparam urxsf_resp_t RESP_OKAY = 2'h0;
	localparam urxsf_resp_t RESP_SLVERR = 2'h2;

	logic [3:0] ctrl_q;
	logic [2:0] irq_en_q;
	urxsf_char_s fifo_q [DEPTH];
	logic [DEPTH-1:0] valid_q;
	logic overrun_error_flag_q;
	logic [3:0] aw_q;
	logic [31:0] w_q;
	logic aw_have_q;
	logic w_have_q;
	urxsf_wst_e wst_q;
	logic [31:0] rdata_q;
	logic rvalid_q;
	urxsf_resp_t rresp_q;
	logic [1:0] bresp_q;
	logic wstrb_lo_q;

	logic serial_port_enable;
	logic continuous_rx_enable;
	logic address_detect_enable;
	logic rx_ready_flag;
	logic accept;
	logic pop;
	logic do_write;
	urxsf_char_s head;
	urxsf_char_s in_char;

	assign serial_port_enable = ctrl_q[`URXSF_CTRL_PORT_EN];
	assign continuous_rx_enable = ctrl_q[`URXSF_CTRL_RX_ON];
	assign nine_bit_rx_enable_o = ctrl_q[`URXSF_CTRL_NINE_BIT]; // R16
	// Address filtering only applies while nine-bit reception is configured.
	assign address_detect_enable = ctrl_q[`URXSF_CTRL_ADDR_DET] & ctrl_q[`URXSF_CTRL_NINE_BIT]; // R19
	assign rx_enable_o = serial_port_enable & continuous_rx_enable;

	assign in_char.frame_err = ~rx_stop_ok_i; // R5
	assign in_char.ninth = nine_bit_rx_enable_o ? rx_shift_reg_i[8] : 1'b0;
	assign in_char.data = rx_shift_reg_i[7:0];

	// Filtered characters are dropped before they can touch the FIFO or overrun.
	assign accept = rx_done_i & rx_enable_o & ~overrun_error_flag_q
		& (~address_detect_enable | in_char.ninth); // R20 R14 R9
	assign head = fifo_q[0];
	assign rx_ready_flag = rx_enable_o & valid_q[0]; // R1 R2 R4
	assign rx_irq_o = rx_ready_flag & irq_en_q[`URXSF_IRQ_RX_EN]
		& irq_en_q[`URXSF_IRQ_PERIPH_EN] & irq_en_q[`URXSF_IRQ_GLOBAL_EN]; // R3 R12

	assign pop = s_axi_arvalid_i & s_axi_arready_o & (s_axi_araddr_i[3:2] == 2'(`URXSF_OFF_DATA >> 2)) & valid_q[0];

	// Shift FIFO: entry 0 is always the oldest, so order is preserved.
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			valid_q <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				fifo_q[i] <= '0;
			end
		end else if (!serial_port_enable) begin
			valid_q <= '0; // R10
			for (int i = 0; i < DEPTH; i++) begin
				fifo_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				if (pop) begin
					// R7 R23
					if (i + 1 < DEPTH && valid_q[(i + 1) % DEPTH]) begin
						fifo_q[i] <= fifo_q[(i + 1) % DEPTH];
						valid_q[i] <= 1'b1;
					end else if (accept && valid_q[i]) begin
						fifo_q[i] <= in_char;
						valid_q[i] <= 1'b1;
					end else begin
						valid_q[i] <= 1'b0;
					end
				end else if (accept && !valid_q[i] && (i == 0 || valid_q[(i + DEPTH - 1) % DEPTH])) begin
					fifo_q[i] <= in_char;
					valid_q[i] <= 1'b1;
				end
			end
		end
	end

	// Overrun: a completed character meeting a full FIFO.
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			overrun_error_flag_q <= 1'b0;
		end else if (!rx_enable_o) begin
			overrun_error_flag_q <= 1'b0; // R15
		end else if (rx_done_i && (&valid_q) && !pop && (!address_detect_enable || in_char.ninth)) begin
			overrun_error_flag_q <= 1'b1; // R13
		end
	end

	// Write channel: address and data taken in either order, response after both.
	assign s_axi_awready_o = (wst_q == URXSF_WIDLE) & ~aw_have_q;
	assign s_axi_wready_o = (wst_q == URXSF_WIDLE) & ~w_have_q;
	assign do_write = (wst_q == URXSF_WIDLE) & (aw_have_q | s_axi_awvalid_i) & (w_have_q | s_axi_wvalid_i);

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_q <= '0;
			w_q <= '0;
			wst_q <= URXSF_WIDLE;
			bresp_q <= RESP_OKAY;
		end else begin
			case (wst_q)
				URXSF_WIDLE: begin
					if (s_axi_awvalid_i && s_axi_awready_o) begin
						aw_q <= s_axi_awaddr_i;
						aw_have_q <= 1'b1;
					end
					if (s_axi_wvalid_i && s_axi_wready_o) begin
						w_q <= s_axi_wdata_i;
						w_have_q <= 1'b1;
					end
					if (do_write) begin
						wst_q <= URXSF_WRESP;
					end
				end
				URXSF_WRESP: begin
					aw_have_q <= 1'b0;
					w_have_q <= 1'b0;
					bresp_q <= (aw_q[3:2] == 2'(`URXSF_OFF_CTRL >> 2) || aw_q[3:2] == 2'(`URXSF_OFF_IRQ >> 2))
						? RESP_OKAY : RESP_SLVERR; // R2
					wst_q <= URXSF_WHOLD;
				end
				URXSF_WHOLD: begin
					if (s_axi_bready_i) begin
						wst_q <= URXSF_WIDLE;
					end
				end
				default: wst_q <= URXSF_WIDLE;
			endcase
		end
	end
	assign s_axi_bvalid_o = (wst_q == URXSF_WHOLD);
	assign s_axi_bresp_o = bresp_q;

	// Register writes land in the response cycle, once address and data are both held.
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_q <= `URXSF_CTRL_RST;
			irq_en_q <= `URXSF_IRQ_RST;
		end else if (wst_q == URXSF_WRESP && wstrb_lo_q) begin
			if (aw_q[3:2] == 2'(`URXSF_OFF_CTRL >> 2)) begin
				ctrl_q <= w_q[3:0];
			end
			if (aw_q[3:2] == 2'(`URXSF_OFF_IRQ >> 2)) begin
				irq_en_q <= w_q[2:0];
			end
		end
	end

	// Only the low byte lane carries register bits, so a write without it changes nothing.
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wstrb_lo_q <= 1'b0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			wstrb_lo_q <= s_axi_wstrb_i[0];
		end
	end

	// Read channel: one read at a time; status reflects the oldest entry.
	assign s_axi_arready_o = ~rvalid_q;
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			rvalid_q <= 1'b1;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
			case (s_axi_araddr_i[3:2])
				2'h0: rdata_q <= {28'h0, ctrl_q};
				2'h1: rdata_q <= {28'h0, head.ninth & valid_q[0], overrun_error_flag_q,
					head.frame_err & valid_q[0], rx_ready_flag}; // R6 R17 R11
				2'h2: rdata_q <= {24'h0, head.data};
				2'h3: rdata_q <= {29'h0, irq_en_q};
				default: rresp_q <= RESP_SLVERR;
			endcase
		end else if (rvalid_q && s_axi_rready_i) begin
			rvalid_q <= 1'b0;
		end
	end
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rdata_o = rdata_q;
	assign s_axi_rresp_o = rresp_q;

	property p_irq_gate;
		@(posedge clock_i) disable iff (sys_rst_i)
		rx_irq_o |-> (rx_ready_flag && (&irq_en_q));
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without all enables"); // R3

	property p_rdy_occ;
		@(posedge clock_i) disable iff (sys_rst_i)
		accept |=> (rx_ready_flag || !rx_enable_o);
	endproperty
	a_rdy_occ: assert property (p_rdy_occ) else $error("ready flag not occupancy"); // R1

	property p_ovr_set;
		@(posedge clock_i) disable iff (sys_rst_i)
		(rx_enable_o && rx_done_i && (&valid_q) && !pop && !address_detect_enable
			&& ctrl_q == $past(ctrl_q)) |=> (overrun_error_flag_q || !rx_enable_o);
	endproperty
	a_ovr_set: assert property (p_ovr_set) else $error("overrun missed"); // R13

	property p_ovr_block;
		@(posedge clock_i) disable iff (sys_rst_i)
		overrun_error_flag_q |-> !accept;
	endproperty
	a_ovr_block: assert property (p_ovr_block) else $error("char accepted during overrun"); // R14

	property p_ovr_hold;
		@(posedge clock_i) disable iff (sys_rst_i)
		(overrun_error_flag_q && rx_enable_o) |=> (overrun_error_flag_q || !$past(rx_enable_o) || !rx_enable_o);
	endproperty
	a_ovr_hold: assert property (p_ovr_hold) else $error("overrun cleared early"); // R15

	property p_port_clr;
		@(posedge clock_i) disable iff (sys_rst_i)
		!serial_port_enable |=> !valid_q[0];
	endproperty
	a_port_clr: assert property (p_port_clr) else $error("fifo kept after port disable"); // R10

	property p_addr_filter;
		@(posedge clock_i) disable iff (sys_rst_i)
		(address_detect_enable && rx_done_i && !rx_shift_reg_i[8]) |-> !accept;
	endproperty
	a_addr_filter: assert property (p_addr_filter) else $error("data char passed filter"); // R20

	property p_pop_adv;
		@(posedge clock_i) disable iff (sys_rst_i)
		(pop && valid_q[1] && serial_port_enable) |=> (head == $past(fifo_q[1]));
	endproperty
	a_pop_adv: assert property (p_pop_adv) else $error("pop did not advance"); // R7

	property p_frame_pass;
		@(posedge clock_i) disable iff (sys_rst_i)
		(rx_done_i && !rx_stop_ok_i && rx_enable_o && !overrun_error_flag_q && !address_detect_enable)
			|-> accept;
	endproperty
	a_frame_pass: assert property (p_frame_pass) else $error("framing error blocked reception"); // R9

	property p_head_load;
		@(posedge clock_i) disable iff (sys_rst_i)
		(accept && !valid_q[0]) |=> (head == $past(in_char));
	endproperty
	a_head_load: assert property (p_head_load) else $error("first character or its framing bit lost"); // R5

	property p_ninth_keep;
		@(posedge clock_i) disable iff (sys_rst_i)
		(accept && nine_bit_rx_enable_o && !valid_q[0]) |=> (head.ninth == $past(rx_shift_reg_i[8]));
	endproperty
	a_ninth_keep: assert property (p_ninth_keep) else $error("ninth bit not stored"); // R17

	property p_occ_hold;
		@(posedge clock_i) disable iff (sys_rst_i)
		(!accept && !pop && serial_port_enable) |=> (valid_q == $past(valid_q));
	endproperty
	a_occ_hold: assert property (p_occ_hold) else $error("occupancy moved without character or pop"); // R2

	property p_ovr_clear;
		@(posedge clock_i) disable iff (sys_rst_i)
		!rx_enable_o |=> !overrun_error_flag_q;
	endproperty
	a_ovr_clear: assert property (p_ovr_clear) else $error("overrun kept after receive disable"); // R15

	property p_stat_ro;
		@(posedge clock_i) disable iff (sys_rst_i)
		(wst_q == URXSF_WRESP && aw_q[3:2] == 2'(`URXSF_OFF_STAT >> 2)) |=> (s_axi_bresp_o == RESP_SLVERR);
	endproperty
	a_stat_ro: assert property (p_stat_ro) else $error("status write not refused"); // R2

	c_ovr: cover property (@(posedge clock_i) disable iff (sys_rst_i) $rose(overrun_error_flag_q));
	c_irq: cover property (@(posedge clock_i) disable iff (sys_rst_i) $rose(rx_irq_o));
	c_frame: cover property (@(posedge clock_i) disable iff (sys_rst_i) accept && in_char.frame_err);
	c_addr_drop: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		rx_done_i && address_detect_enable && !rx_shift_reg_i[8]);
	c_pop_shift: cover property (@(posedge clock_i) disable iff (sys_rst_i) pop && valid_q[1]);
endmodule

// ### sim/urxsf_line_model.sv
// Purpose: Remote serial transmitter as seen after the shifter, one strobe per finished character.
// Assumes: The bench calls send right after a rising clock edge.
// Notes: Between characters the data lines show the inverse of the last value.
`timescale 1ns/10ps
module urxsf_line_model (
	input wire logic clock_i,
	input wire logic nine_bit_i,
	output logic done_o,
	output logic [8:0] bits_o,
	output logic stop_ok_o
);
	initial begin
		done_o = 1'b0;
		bits_o = 9'h000;
		stop_ok_o = 1'b1;
	end
	// A ninth bit only exists on the line when nine-bit framing is selected.
	task automatic send(input logic [8:0] ch, input logic ok);
		@(posedge clock_i);
		done_o <= 1'b1;
		bits_o <= nine_bit_i ? ch : {1'b0, ch[7:0]};
		stop_ok_o <= ok;
		@(posedge clock_i);
		done_o <= 1'b0;
		bits_o <= ~ch;
		stop_ok_o <= ~ok;
	endtask
endmodule

// ### sim/tb_urxsf_top.sv
// Purpose: Self-checking bench for the receive status block over its register bus.
// Assumes: Characters come from the line model; software is modelled by the bus tasks.
// Notes: Handshakes are sampled on the falling edge half a cycle before each rising edge and acted on right after it.
`timescale 1ns/10ps
`include "urxsf_map.svh"
module tb_urxsf_top;
	import urxsf_pkg::*;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic rx_done, stop_ok, nine, rx_en, irq;
	logic [8:0] bits;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rd;
	logic [1:0] rs;
	int n_mismatch = 0;
	int n_compared = 0;
	always #5 clock_i = ~clock_i;
	urxsf_top urxsf_top_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .rx_done_i(rx_done),
		.rx_shift_reg_i(bits), .rx_stop_ok_i(stop_ok), .nine_bit_rx_enable_o(nine), .rx_enable_o(rx_en),
		.rx_irq_o(irq), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
	urxsf_line_model urxsf_line_model_inst (.clock_i(clock_i), .nine_bit_i(nine), .done_o(rx_done),
		.bits_o(bits), .stop_ok_o(stop_ok));
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic timeout();
		n_mismatch++;
		$display("[ERR] t=%0t seen=%h expected=%h", $time, 32'h0, 32'h1);
		final_report();
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ha, hw, hb;
		@(posedge clock_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(negedge clock_i);
			ha = awvalid & awready;
			hw = wvalid & wready;
			hb = bvalid & bready;
			r = bresp;
			@(posedge clock_i);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) begin
				bready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask
	task automatic rdr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ha, hr;
		@(posedge clock_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(negedge clock_i);
			ha = arvalid & arready;
			hr = rvalid & rready;
			d = rdata;
			r = rresp;
			@(posedge clock_i);
			if (ha) arvalid <= 1'b0;
			if (hr) begin
				rready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
		rdr(a, rd, rs);
		chk(rd, exp);
	endtask
	task automatic ctl(input logic [31:0] v);
		wr(`URXSF_OFF_CTRL, v, rs);
	endtask
	initial begin
		repeat (6) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		@(posedge clock_i);
		rchk(`URXSF_OFF_CTRL, 32'h0);
		rchk(`URXSF_OFF_IRQ, 32'h0);
		rchk(`URXSF_OFF_STAT, 32'h0);
		rdr(4'h2, rd, rs);
		chk(rd, 32'h0);
		chk(32'(rs), 32'h0);
		$display("test reset and map done");
		ctl(32'h3);
		chk(32'(rs), 32'h0);
		urxsf_line_model_inst.send(9'h041, 1'b1);
		urxsf_line_model_inst.send(9'h042, 1'b0);
		wr(`URXSF_OFF_STAT, 32'h0, rs);
		chk(32'(rs), 32'h2);
		rchk(`URXSF_OFF_STAT, 32'h1);
		rchk(`URXSF_OFF_DATA, 32'h41);
		rchk(`URXSF_OFF_STAT, 32'h3);
		for (int v = 0; v < 8; v++) begin
			wr(`URXSF_OFF_IRQ, v, rs);
			rchk(`URXSF_OFF_IRQ, v);
			chk(32'(irq), 32'(v == 7));
		end
		rchk(`URXSF_OFF_DATA, 32'h42);
		chk(32'(irq), 32'h0);
		rchk(`URXSF_OFF_STAT, 32'h0);
		$display("test order, framing and interrupt done");
		urxsf_line_model_inst.send(9'h051, 1'b0);
		urxsf_line_model_inst.send(9'h052, 1'b1);
		urxsf_line_model_inst.send(9'h053, 1'b1);
		rchk(`URXSF_OFF_STAT, 32'h7);
		urxsf_line_model_inst.send(9'h054, 1'b1);
		rchk(`URXSF_OFF_STAT, 32'h7);
		ctl(32'h1);
		rchk(`URXSF_OFF_STAT, 32'h2);
		ctl(32'h3);
		rchk(`URXSF_OFF_DATA, 32'h51);
		rchk(`URXSF_OFF_DATA, 32'h52);
		rchk(`URXSF_OFF_STAT, 32'h0);
		urxsf_line_model_inst.send(9'h061, 1'b0);
		ctl(32'h0);
		rchk(`URXSF_OFF_STAT, 32'h0);
		ctl(32'h3);
		rchk(`URXSF_OFF_STAT, 32'h0);
		$display("test overrun and port disable done");
		ctl(32'h7);
		chk(32'({nine, rx_en}), 32'h3);
		urxsf_line_model_inst.send(9'h1A5, 1'b1);
		rchk(`URXSF_OFF_STAT, 32'h9);
		rchk(`URXSF_OFF_DATA, 32'hA5);
		ctl(32'hF);
		urxsf_line_model_inst.send(9'h055, 1'b1);
		urxsf_line_model_inst.send(9'h133, 1'b1);
		rchk(`URXSF_OFF_STAT, 32'h9);
		rchk(`URXSF_OFF_DATA, 32'h33);
		ctl(32'h7);
		urxsf_line_model_inst.send(9'h044, 1'b1);
		rchk(`URXSF_OFF_STAT, 32'h1);
		rchk(`URXSF_OFF_DATA, 32'h44);
		ctl(32'hF);
		urxsf_line_model_inst.send(9'h066, 1'b1);
		rchk(`URXSF_OFF_STAT, 32'h0);
		$display("test nine-bit and address filter done");
		final_report();
	end
endmodule
